//--- src/ccu_unit.sv
// One capture/compare unit: value pair, flag, prescaler, compare output latch.
// Assumes Timer1 count and tick are synchronous to clock_i.
`timescale 1ns/10ps
module ccu_unit
    import ccu_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Software side
    input wire logic [3:0] mode_i,
    input wire logic ctrl_wr_i,
    input wire logic val_wr_i,
    input wire logic [WIDTH-1:0] val_wdata_i,
    input wire logic flag_clr_i,
    // Timer1, pin and ADC enable
    input wire logic [WIDTH-1:0] tmr_count_i,
    input wire logic tmr_tick_i,
    input wire logic pin_i,
    input wire logic adc_enable_i,
    // Results
    output logic [WIDTH-1:0] value_o,
    output logic flag_o,
    output logic cmp_out_o,
    output logic pin_owned_o,
    output logic conv_trig_o,
    output logic tmr_reset_o
);

    // ****************************************************************
    // Decode and pin edge
    // ****************************************************************
    logic pin_d_r;
    logic [3:0] presc_r;
    logic [3:0] presc_nxt;
    logic cap_mode;
    logic cmp_mode;
    logic rise;
    logic fall;
    logic cap_evt;
    logic eq;
    logic eq_d_r;
    logic match;
    ccu_trig_state_t trig_st_r;

    assign cap_mode = (mode_i[3:2] == 2'b01);
    assign cmp_mode = mode_i[3] | (mode_i == MODE_CMP_TOGGLE);
    assign rise = pin_i & ~pin_d_r;
    assign fall = ~pin_i & pin_d_r;
    assign eq = (tmr_count_i == value_o);
    assign match = cmp_mode & eq & ~eq_d_r;

    always_comb begin
        presc_nxt = presc_r + 4'h1;
        cap_evt = 1'b0;
        case (mode_i)
            MODE_CAP_FALL: cap_evt = fall;
            MODE_CAP_RISE: cap_evt = rise;
            MODE_CAP_RISE4: cap_evt = rise & (presc_r[1:0] == PRESC_4_LAST[1:0]);
            MODE_CAP_RISE16: cap_evt = rise & (presc_r == PRESC_16_LAST);
            default: cap_evt = 1'b0;
        endcase
    end

    // Pin sampled regardless of direction
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pin_d_r <= 1'b0;
        end else if (clk_en_i) begin
            pin_d_r <= pin_i;
        end
    end

    // Prescaler survives prescale changes on purpose
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            presc_r <= PRESC_RESET;
        end else if (clk_en_i) begin
            if (!cap_mode) begin
                presc_r <= PRESC_RESET;
            end else if (rise) begin
                presc_r <= presc_nxt;
            end
        end
    end

    // ****************************************************************
    // Value pair and flag
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            value_o <= VALUE_RESET;
        end else if (clk_en_i) begin
            if (cap_mode && cap_evt) begin
                value_o <= tmr_count_i;
            end else if (val_wr_i) begin
                value_o <= val_wdata_i;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            flag_o <= 1'b0;
        end else if (clk_en_i) begin
            if ((cap_mode && cap_evt) || match) begin
                flag_o <= 1'b1;
            end else if (flag_clr_i) begin
                flag_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            eq_d_r <= 1'b0;
        end else if (clk_en_i) begin
            eq_d_r <= eq;
        end
    end

    // ****************************************************************
    // Compare output latch and pin ownership
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cmp_out_o <= 1'b0;
        end else if (clk_en_i) begin
            if (ctrl_wr_i && mode_i == MODE_OFF) begin
                cmp_out_o <= 1'b0;
            end else if (match) begin
                case (mode_i)
                    MODE_CMP_SET: cmp_out_o <= 1'b1;
                    MODE_CMP_CLR: cmp_out_o <= 1'b0;
                    MODE_CMP_TOGGLE: cmp_out_o <= ~cmp_out_o;
                    default: cmp_out_o <= cmp_out_o;
                endcase
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pin_owned_o <= 1'b0;
        end else if (clk_en_i) begin
            pin_owned_o <= (mode_i == MODE_CMP_SET) || (mode_i == MODE_CMP_CLR)
                || (mode_i == MODE_CMP_TOGGLE);
        end
    end

    // ****************************************************************
    // Conversion trigger and deferred Timer1 reset
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            conv_trig_o <= 1'b0;
        end else if (clk_en_i) begin
            conv_trig_o <= match && (mode_i == MODE_CMP_TRIG)
                && adc_enable_i;
        end
    end

    // Reset only on a Timer1 tick; overflow flag is never touched here
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            trig_st_r <= CCU_IDLE;
            tmr_reset_o <= 1'b0;
        end else if (clk_en_i) begin
            tmr_reset_o <= 1'b0;
            case (trig_st_r)
                CCU_IDLE: begin
                    if (match && mode_i == MODE_CMP_TRIG) begin
                        trig_st_r <= CCU_PEND;
                    end
                end
                CCU_PEND: begin
                    if (!eq || mode_i != MODE_CMP_TRIG) begin
                        trig_st_r <= CCU_IDLE;
                    end else if (tmr_tick_i) begin
                        tmr_reset_o <= 1'b1;
                        trig_st_r <= CCU_HOLD;
                    end
                end
                CCU_HOLD: trig_st_r <= CCU_IDLE;
                default: trig_st_r <= CCU_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    flag_on_capture_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && cap_mode && cap_evt) |=> flag_o)
        else $error("capture did not set flag");
    value_captured_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && cap_mode && cap_evt) |=> (value_o == $past(tmr_count_i)))
        else $error("capture value wrong");
    flag_sticky_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (flag_o && !flag_clr_i) |=> flag_o)
        else $error("flag dropped without clear");
    presc_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && !cap_mode) |=> (presc_r == PRESC_RESET))
        else $error("prescaler not cleared");
    match_flag_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && match) |=> flag_o)
        else $error("match did not set flag");
    once_per_match_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && match) |=> !match)
        else $error("repeated match action");
    off_clears_out_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && ctrl_wr_i && mode_i == MODE_OFF) |=> !cmp_out_o)
        else $error("compare latch not forced low");
    trig_immediate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && match && mode_i == MODE_CMP_TRIG && adc_enable_i) |=> conv_trig_o)
        else $error("conversion trigger late");
    reset_needs_eq_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && trig_st_r == CCU_PEND && !eq) |=> !tmr_reset_o)
        else $error("reset issued without match");

endmodule : ccu_unit

//--- src/ccu_pkg.sv
// Constants, mode codes and reset values for the dual capture/compare unit.
// Assumes a single 250 MHz clock domain; Timer1 lives outside and is seen as a count.
// How it works
// - Two identical units, each with own control, value pair, pin and flag.
// - Capture copies full 16-bit Timer1 count into value high and low registers.
// - Capture event is falling edge, rising edge, every 4th or 16th rising edge.
// - Capture sets event flag; only software clears it.
// - A newer capture simply overwrites the stored value.
// - Pin level is sampled whatever the pin direction is.
// - Mode change may set flag falsely; software masks and clears it.
// - Prescaler counter clears when off, not capturing, or in reset.
// - Switching prescale keeps counter; software writes zero control first.
// - Capture works while Timer1 has its own clock; counts hold in sleep.
// - Compare checks value pair against Timer1 count every cycle.
// - Match toggles, sets or clears output, triggers conversion, or only flags.
// - Any compare match sets the event flag in the same cycle as the pin action or conversion trigger.
// - Zero control forces compare output latch low; port latch untouched.
// - Mode 1010 raises only the event flag and leaves the pin alone.
// - Mode 1011 resets Timer1 and requests conversion when ADC enabled.
// - Conversion trigger is immediate; Timer1 reset waits for next Timer1 tick.
// - Conversion-trigger reset never sets the Timer1 overflow flag.
// - Pending Timer1 reset is dropped if the match no longer holds.
// - Compare need not work while the system clock is stopped.
// - Timer1 external clock is resynchronized when sync disable is zero.
package ccu_pkg;

    // ****************************************************************
    // Mode codes of unit_mode_select
    // ****************************************************************
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;

    // ****************************************************************
    // Counts and reset values
    // ****************************************************************
    localparam logic [3:0] PRESC_4_LAST = 4'h3;
    localparam logic [3:0] PRESC_16_LAST = 4'hF;
    localparam logic [3:0] PRESC_RESET = 4'h0;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam int NUM_UNITS = 2;

    typedef enum logic [2:0] {
        CCU_IDLE = 3'b001,
        CCU_PEND = 3'b010,
        CCU_HOLD = 3'b100
    } ccu_trig_state_t;

endpackage : ccu_pkg

//--- src/ccu_top.sv
// Top of the dual capture/compare block; instantiates two identical units.
// Assumes Timer1, port latches and ADC sit outside and talk through plain ports.
`timescale 1ns/10ps
module ccu_top
    import ccu_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Per-unit control (unit 0 in low bits)
    input wire logic [4*NUM_UNITS-1:0] unit_mode_select_i,
    input wire logic [NUM_UNITS-1:0] unit_control_wr_i,
    input wire logic [NUM_UNITS-1:0] value_wr_i,
    input wire logic [WIDTH-1:0] value_wdata_i,
    input wire logic [NUM_UNITS-1:0] unit_event_flag_clr_i,
    // Timer1, pins and ADC
    input wire logic [WIDTH-1:0] timer1_count_i,
    input wire logic timer1_tick_i,
    input wire logic [NUM_UNITS-1:0] unit_io_pin_i,
    input wire logic adc_enable_i,
    // Per-unit results
    output logic [WIDTH*NUM_UNITS-1:0] value_o,
    output logic [NUM_UNITS-1:0] unit_event_flag_o,
    output logic [NUM_UNITS-1:0] cmp_out_o,
    output logic [NUM_UNITS-1:0] pin_owned_o,
    output logic [NUM_UNITS-1:0] conv_trig_o,
    output logic [NUM_UNITS-1:0] timer1_reset_o
);

    // ****************************************************************
    // Identical units
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
            ccu_unit #(
                .WIDTH(WIDTH)
            ) u_unit (
                .clock_i(clock_i),
                .rst_n_i(rst_n_i),
                .clk_en_i(clk_en_i),
                .mode_i(unit_mode_select_i[4*gi +: 4]),
                .ctrl_wr_i(unit_control_wr_i[gi]),
                .val_wr_i(value_wr_i[gi]),
                .val_wdata_i(value_wdata_i),
                .flag_clr_i(unit_event_flag_clr_i[gi]),
                .tmr_count_i(timer1_count_i),
                .tmr_tick_i(timer1_tick_i),
                .pin_i(unit_io_pin_i[gi]),
                .adc_enable_i(adc_enable_i),
                .value_o(value_o[WIDTH*gi +: WIDTH]),
                .flag_o(unit_event_flag_o[gi]),
                .cmp_out_o(cmp_out_o[gi]),
                .pin_owned_o(pin_owned_o[gi]),
                .conv_trig_o(conv_trig_o[gi]),
                .tmr_reset_o(timer1_reset_o[gi])
            );
        end
    endgenerate

endmodule : ccu_top

//--- verification/ccu_tmr_model.sv
// Timer1 model facing the capture/compare block: count, tick, overflow.
// Assumes one clock; the bench starts, stops and loads the count.
`timescale 1ns/10ps
module ccu_tmr_model (
    // Clock and control
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic load_i,
    input wire logic [15:0] load_val_i,
    input wire logic [1:0] reset_req_i,
    // Timer state
    output logic [15:0] count_o,
    output logic tick_o,
    output logic ovf_o
);
    logic [1:0] div_r;

    // Tick every 4th cycle, never at the system clock rate
    always_ff @(posedge clock_i) begin
        div_r <= (!rst_n_i || !run_i) ? 2'h0 : div_r + 2'h1;
    end
    assign tick_o = run_i && (div_r == 2'h3);

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            count_o <= 16'h0000;
            ovf_o <= 1'b0;
        end else if (load_i) begin
            count_o <= load_val_i;
        end else if (|reset_req_i) begin
            count_o <= 16'h0000;
        end else if (tick_o) begin
            count_o <= count_o + 16'h0001;
            ovf_o <= ovf_o | (count_o == 16'hFFFF);
        end
    end
endmodule : ccu_tmr_model

//--- verification/ccu_top_tb.sv
// Self-checking bench for the dual capture/compare block.
// Assumes the Timer1 model is compiled before it; pins are inputs here.
`timescale 1ns/10ps
module ccu_top_tb
    import ccu_pkg::*;
();
    typedef struct packed {
        logic [3:0] mode;
        logic [4:0] pulses;
        logic [15:0] v;
        logic adc;
        logic [3:0] want;
    } ccu_row_t;

    logic clk, rst_n, clk_en, adc_en, run, load, tick, ovf;
    logic [7:0] mode;
    logic [1:0] cwr, vwr, fclr, pin, flag, cmp, own, conv, treq;
    logic [15:0] wdata, load_val, count;
    logic [31:0] value;
    int failures, compares;
    int cycles = 0;
    // Expectations: flag, compare out, pin owned, trigger
    ccu_row_t rows [13] = '{
        '{MODE_CAP_RISE, 5'd1, 16'h1234, 1'b0, 4'h8},
        '{MODE_CAP_RISE4, 5'd3, 16'h2345, 1'b0, 4'h0},
        '{MODE_CAP_RISE4, 5'd4, 16'h3456, 1'b0, 4'h8},
        '{MODE_CAP_RISE16, 5'd15, 16'h4567, 1'b0, 4'h0},
        '{MODE_CAP_RISE16, 5'd16, 16'h5678, 1'b0, 4'h8},
        '{MODE_CAP_FALL, 5'd1, 16'h6789, 1'b0, 4'h8},
        '{MODE_CMP_SET, 5'd0, 16'h0100, 1'b0, 4'hE},
        '{MODE_CMP_CLR, 5'd0, 16'h0200, 1'b0, 4'hA},
        '{MODE_CMP_TOGGLE, 5'd0, 16'h0300, 1'b0, 4'hE},
        '{MODE_CMP_TOGGLE, 5'd0, 16'h0400, 1'b0, 4'hA},
        '{MODE_CMP_SOFT, 5'd0, 16'h0500, 1'b0, 4'h8},
        '{MODE_CMP_TRIG, 5'd0, 16'h0600, 1'b1, 4'h9},
        '{MODE_CMP_TRIG, 5'd0, 16'h0700, 1'b0, 4'h8}};

    ccu_top #(.WIDTH(16)) u_ccu_top (
        .clock_i(clk), .rst_n_i(rst_n), .clk_en_i(clk_en),
        .unit_mode_select_i(mode), .unit_control_wr_i(cwr), .value_wr_i(vwr),
        .value_wdata_i(wdata), .unit_event_flag_clr_i(fclr), .timer1_count_i(count),
        .timer1_tick_i(tick), .unit_io_pin_i(pin), .adc_enable_i(adc_en),
        .value_o(value), .unit_event_flag_o(flag), .cmp_out_o(cmp),
        .pin_owned_o(own), .conv_trig_o(conv), .timer1_reset_o(treq));

    ccu_tmr_model u_ccu_tmr_model (
        .clock_i(clk), .rst_n_i(rst_n), .run_i(run), .load_i(load),
        .load_val_i(load_val), .reset_req_i(treq), .count_o(count),
        .tick_o(tick), .ovf_o(ovf));

    // ********************
    // Shared tasks
    // ********************
    task automatic final_report();
        $display("Counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // Strobes drop for a cycle so back-to-back calls never collide
    task automatic strobe(input int k, input int u);
        if (k == 0) cwr[u] = 1'b1;
        else if (k == 1) vwr[u] = 1'b1;
        else fclr[u] = 1'b1;
        cyc(1);
        cwr = 2'b00;
        vwr = 2'b00;
        fclr = 2'b00;
        cyc(1);
    endtask : strobe

    task automatic set_mode(input int u, input logic [3:0] m);
        mode[4*u+:4] = m;
        strobe(0, u);
    endtask : set_mode

    task automatic wr_val(input int u, input logic [15:0] v);
        wdata = v;
        strobe(1, u);
    endtask : wr_val

    task automatic load_tmr(input logic [15:0] v);
        run = 1'b0;
        load = 1'b1;
        load_val = v;
        cyc(1);
        load = 1'b0;
        cyc(1);
    endtask : load_tmr

    task automatic pulse(input int u);
        pin[u] = 1'b1;
        cyc(2);
        pin[u] = 1'b0;
        cyc(2);
    endtask : pulse

    task automatic wait_flag(input int u);
        int n;
        n = 0;
        while (flag[u] !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        check(32'(flag[u]), 32'h1, "match flag");
    endtask : wait_flag

    task automatic do_row(input ccu_row_t r);
        if (r.mode[3:2] == 2'b01) begin
            set_mode(0, MODE_OFF);
            set_mode(0, r.mode);
            load_tmr(r.v);
            wr_val(0, 16'h0000);
            strobe(2, 0);
            repeat (r.pulses) pulse(0);
            cyc(3);
            check(32'(flag[0]), 32'(r.want[3]), "capture flag");
            check(32'(value[15:0]), r.want[3] ? 32'(r.v) : 32'h0, "capture");
        end else begin
            set_mode(0, r.mode);
            wr_val(0, r.v);
            load_tmr(r.v - 16'h0003);
            adc_en = r.adc;
            strobe(2, 0);
            run = 1'b1;
            wait_flag(0);
            check(32'(conv[0]), 32'(r.want[0]), "trigger");
            check(32'(cmp[0]), 32'(r.want[2]), "compare out");
            check(32'(own[0]), 32'(r.want[1]), "pin owned");
            cyc(6);
            check(32'(count < 16'h0002), 32'(r.mode == MODE_CMP_TRIG), "timer");
            check(32'(ovf), 32'h0, "overflow");
            run = 1'b0;
        end
    endtask : do_row

    // ********************
    // Clock, timeout, tests
    // ********************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Whole run is under 2000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            final_report();
        end
    end

    initial begin
        {rst_n, adc_en, run, load, cwr, vwr, fclr, pin} = '0;
        {mode, wdata, load_val} = '0;
        {failures, compares} = '0;
        clk_en = 1'b1;
        cyc(5);
        check(value, 32'h0, "reset value");
        check(32'({flag, cmp, own, conv, treq}), 32'h0, "reset outputs");
        rst_n = 1'b1;
        cyc(1);
        for (int i = 0; i < 13; i++) begin
            do_row(rows[i]);
            $display("Test row %0d done", i);
        end
        set_mode(0, MODE_OFF);
        set_mode(0, MODE_CAP_RISE);
        strobe(2, 0);
        load_tmr(16'hA5A5);
        pulse(0);
        load_tmr(16'h5A5A);
        pulse(0);
        cyc(8);
        check(32'(value[15:0]), 32'h5A5A, "overwrite");
        check(32'(flag[0]), 32'h1, "sticky flag");
        set_mode(0, MODE_CAP_RISE4);
        repeat (3) pulse(0);
        set_mode(0, MODE_OFF);
        set_mode(0, MODE_CAP_RISE4);
        strobe(2, 0);
        pulse(0);
        cyc(3);
        check(32'(flag[0]), 32'h0, "prescaler");
        $display("Test capture hazards done");
        set_mode(0, MODE_OFF);
        set_mode(1, MODE_CAP_RISE);
        load_tmr(16'hBEEF);
        strobe(2, 0);
        strobe(2, 1);
        pulse(1);
        cyc(3);
        check(32'(value[31:16]), 32'hBEEF, "unit 1");
        check(32'(flag), 32'h2, "unit flags");
        strobe(2, 1);
        load_tmr(16'h1357);
        clk_en = 1'b0;
        pulse(1);
        clk_en = 1'b1;
        cyc(2);
        check(32'(value[31:16]), 32'hBEEF, "frozen value");
        check(32'(flag), 32'h0, "frozen flag");
        $display("Test unit 1 and freeze done");
        do_row(ccu_row_t'{MODE_CMP_SET, 5'd0, 16'h0A00, 1'b0, 4'hE});
        set_mode(0, MODE_OFF);
        check(32'(cmp[0]), 32'h0, "zero write");
        set_mode(0, MODE_CMP_SOFT);
        load_tmr(16'h0777);
        strobe(2, 0);
        wr_val(0, 16'h0777);
        cyc(2);
        check(32'(flag[0]), 32'h1, "match on write");
        strobe(2, 0);
        cyc(5);
        check(32'(flag[0]), 32'h0, "single match");
        set_mode(0, MODE_CMP_TRIG);
        wr_val(0, 16'h0900);
        load_tmr(16'h08FD);
        strobe(2, 0);
        run = 1'b1;
        wait_flag(0);
        wr_val(0, 16'h0F00);
        cyc(6);
        check(32'(count >= 16'h0900), 32'h1, "reset dropped");
        run = 1'b0;
        $display("Test compare hazards done");
        rst_n = 1'b0;
        cyc(2);
        check(value, 32'h0, "mid reset value");
        check(32'({flag, cmp, own, conv, treq}), 32'h0, "mid reset outputs");
        rst_n = 1'b1;
        cyc(1);
        $display("Test mid-run reset done");
        final_report();
    end
endmodule : ccu_top_tb
